// >>> include/sapr_regs.svh
// Timing counts and bit positions for the parallel readout converter control.
`ifndef SAPR_REGS_SVH
`define SAPR_REGS_SVH
`define SAPR_RES_BITS      12
`define SAPR_MSB           11
`define SAPR_CLK_MHZ       200
`define SAPR_CONV_MAX_NS   6000
`define SAPR_CONV_MAX_CYC  ((`SAPR_CONV_MAX_NS * `SAPR_CLK_MHZ) / 1000)
`define SAPR_STEP_NS       400
`define SAPR_STEP_CYC      ((`SAPR_STEP_NS * `SAPR_CLK_MHZ) / 1000)
`define SAPR_SAMPLE_MIN_NS 1000
`define SAPR_HI_NIB_LSB    8
`endif

// >>> include/sapr_pkg.sv
// Types shared by the converter control modules.
package sapr_pkg;
  typedef enum logic [1:0] {
    SAPR_IDLE,
    SAPR_CLEAR,
    SAPR_STEP,
    SAPR_LOAD
  } sapr_state_t;
endpackage

// >>> include/sapr_pins_if.sv
// Interface carrying the gated host strobes between control and pin driver.
`timescale 1ns/10ps
interface sapr_pins_if;
  logic        drive_en;
  logic        high_byte;
  logic [11:0] latch_val;
  modport ctrl (output drive_en, output high_byte, output latch_val);
  modport drv  (input  drive_en, input  high_byte, input  latch_val);
endinterface

// >>> verilog/sapr_pin_drv.sv
// Data pin driver: maps the output latch onto the twelve three-state pins.
`timescale 1ns/10ps
`include "sapr_regs.svh"
module sapr_pin_drv (
  input  wire logic        clk_i,
  input  wire logic        rstn_i,
  sapr_pins_if.drv         pins,
  output logic      [11:0] data_o,
  output logic      [11:0] data_oe_n_o
);
  logic [11:0] data_reg;
  logic [11:0] data_next;
  logic [11:0] oen_reg;
  logic [11:0] oen_next;

  // Byte-select mux; middle nibble forced low in two-byte mode.
  always_comb begin
    if (pins.high_byte) begin
      data_next = {pins.latch_val[11:8], 4'h0, pins.latch_val[11:8]};
    end else begin
      data_next = pins.latch_val;
    end
  end

  // One enable per pin, all low while the host read is active.
  genvar gi;
  generate
    for (gi = 0; gi < `SAPR_RES_BITS; gi = gi + 1) begin : g_oe
      assign oen_next[gi] = ~pins.drive_en;
    end
  endgenerate

  // Registered outputs; pins float out of reset.
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      data_reg <= 12'h000;
      oen_reg  <= 12'hFFF;
    end else begin
      data_reg <= data_next;
      oen_reg  <= oen_next;
    end
  end

  assign data_o      = data_reg;
  assign data_oe_n_o = oen_reg;
endmodule

// >>> verilog/sapr_ctrl.sv
// Successive-approximation converter control with a parallel host read port.
`timescale 1ns/10ps
`include "sapr_regs.svh"
// Operation
// - Read low with select, byte-low starts conversion
// - High byte select blocks conversion start
// - Drive data pins only during select and read
// - Select high ignores read and byte select
// - Busy low throughout conversion
// - Byte select low gives full word
// - Byte select high duplicates top nibble
// - Start clears approximation register, enables outputs
// - Starts ignored while converting
// - One bit per step, MSB first
// - End of conversion loads output latch
// - Conversion finishes within six microseconds
module sapr_ctrl (
  input  wire logic        clk_i,
  input  wire logic        rstn_i,
  input  wire logic        select_n_i,
  input  wire logic        read_n_i,
  input  wire logic        high_byte_select_i,
  input  wire logic        comp_i,
  output logic      [11:0] dac_code_o,
  output logic             busy_n_o,
  output logic      [11:0] data_o,
  output logic      [11:0] data_oe_n_o
);
  // Step period in clock cycles. Twelve steps plus one clear and one load cycle keep busy
  // low for 962 cycles, about 4.8 us, which leaves a fifth of the worst-case budget spare
  // for a slower clock or a longer step without touching the sequencer.
  localparam int          STEP_CYC  = `SAPR_STEP_CYC;
  localparam logic [7:0]  STEP_LAST = 8'(STEP_CYC - 1);
  localparam logic [3:0]  BIT_LAST  = 4'(`SAPR_MSB);
  localparam logic [10:0] CONV_LAST = 11'(`SAPR_CONV_MAX_CYC - 2);

  // Gated strobes and the output latch travel to the pin driver together.
  sapr_pins_if pins ();

  // Three-stage synchronisers for the host pins and the comparator. The host bus runs on its
  // own clock, so stage one may go metastable; it feeds only stage two. A level counts once
  // stages two and three agree, which costs three to four cycles of latency on every strobe
  // but keeps a runt pulse on the read line from starting a conversion.
  logic [2:0] sel_sy_reg;
  logic [2:0] rd_sy_reg;
  logic [2:0] hb_sy_reg;
  logic [2:0] cmp_sy_reg;
  logic [2:0] sel_sy_next;
  logic [2:0] rd_sy_next;
  logic [2:0] hb_sy_next;
  logic [2:0] cmp_sy_next;
  logic       sel_reg;
  logic       rd_reg;
  logic       hb_reg;
  logic       cmp_reg;
  logic       sel_next;
  logic       rd_next;
  logic       hb_next;
  logic       cmp_next;

  // Shift in; the filtered level only moves once stages two and three agree.
  always_comb begin
    sel_sy_next = {sel_sy_reg[1:0], select_n_i};
    rd_sy_next  = {rd_sy_reg[1:0], read_n_i};
    hb_sy_next  = {hb_sy_reg[1:0], high_byte_select_i};
    cmp_sy_next = {cmp_sy_reg[1:0], comp_i};
    // Filtered levels hold their value while stages two and three disagree.
    sel_next    = (sel_sy_reg[1] == sel_sy_reg[2]) ? sel_sy_reg[2] : sel_reg;
    rd_next     = (rd_sy_reg[1] == rd_sy_reg[2]) ? rd_sy_reg[2] : rd_reg;
    hb_next     = (hb_sy_reg[1] == hb_sy_reg[2]) ? hb_sy_reg[2] : hb_reg;
    cmp_next    = (cmp_sy_reg[1] == cmp_sy_reg[2]) ? cmp_sy_reg[2] : cmp_reg;
  end

  // Synchroniser registers; idle bus levels are high.
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sel_sy_reg <= 3'h7;
      rd_sy_reg  <= 3'h7;
      hb_sy_reg  <= 3'h7;
      cmp_sy_reg <= 3'h0;
      sel_reg    <= 1'b1;
      rd_reg     <= 1'b1;
      hb_reg     <= 1'b1;
      cmp_reg    <= 1'b0;
    end else begin
      sel_sy_reg <= sel_sy_next;
      rd_sy_reg  <= rd_sy_next;
      hb_sy_reg  <= hb_sy_next;
      cmp_sy_reg <= cmp_sy_next;
      sel_reg    <= sel_next;
      rd_reg     <= rd_next;
      hb_reg     <= hb_next;
      cmp_reg    <= cmp_next;
    end
  end

  // Start request is level-qualified and edge-detected on the read strobe. A host that keeps
  // read low after a conversion ends must not start another one by itself, so only the falling
  // edge counts; select and byte select are looked at as levels on that same cycle. The edge
  // register rests high, the idle level of the strobe, so no false edge follows reset.
  logic rd_prev_reg;
  logic rd_prev_next;
  logic start_req;
  logic read_act;

  // Read is active only with select low; byte select plays no part in enabling the pins.
  always_comb begin
    rd_prev_next = rd_reg;
    read_act     = ~sel_reg & ~rd_reg;
    start_req    = ~sel_reg & ~hb_reg & rd_prev_reg & ~rd_reg;
  end

  // Previous filtered read level for the edge detector.
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rd_prev_reg <= 1'b1;
    end else begin
      rd_prev_reg <= rd_prev_next;
    end
  end

  // Conversion sequencer with approximation register and output latch. A start moves idle to
  // clear, which empties the approximation register and sets the trial bit on the MSB. Each
  // step then keeps or drops the trial bit on the comparator's verdict and moves it one place
  // down. After the last decision the load cycle copies the register into the output latch,
  // which the pins show until the next load; a read during conversion sees the old result.
  sapr_pkg::sapr_state_t state_reg;
  sapr_pkg::sapr_state_t state_next;
  logic [11:0] sar_reg;
  logic [11:0] sar_next;
  logic [11:0] trial_reg;
  logic [11:0] trial_next;
  logic [11:0] latch_reg;
  logic [11:0] latch_next;
  logic [7:0]  tick_reg;
  logic [7:0]  tick_next;
  logic        step_en;

  // Internal step clock: a one-cycle enable every step period. The tick counter only runs in
  // the step state, so every conversion starts its first step a whole period after the clear,
  // which gives the trial code time to settle at the comparator before it is judged.
  always_comb begin
    step_en = (tick_reg == STEP_LAST);
  end

  // Decision counter. Ending on a count instead of on the trial bit running off the bottom
  // means a disturbed trial register cannot stretch a conversion beyond twelve decisions.
  // It counts decisions, not cycles, and rests at zero outside the step state.
  logic [3:0]  bit_cnt_reg;
  logic [3:0]  bit_cnt_next;
  logic        last_bit;

  always_comb begin
    last_bit = (bit_cnt_reg == BIT_LAST);
    if (state_reg != sapr_pkg::SAPR_STEP) begin
      bit_cnt_next = 4'h0;
    end else if (step_en) begin
      bit_cnt_next = bit_cnt_reg + 4'h1;
    end else begin
      bit_cnt_next = bit_cnt_reg;
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      bit_cnt_reg <= 4'h0;
    end else begin
      bit_cnt_reg <= bit_cnt_next;
    end
  end

  // Conversion watchdog. The step clock already finishes well inside the time limit; this
  // counter is a second guard, so that an upset in the step logic still ends the conversion
  // and raises busy in time. A forced end loads whatever bits were decided so far. The limit
  // leaves two cycles for the load state and the return to idle.
  logic [10:0] conv_cnt_reg;
  logic [10:0] conv_cnt_next;
  logic        conv_late;

  always_comb begin
    conv_late = (conv_cnt_reg == CONV_LAST);
    if (state_reg == sapr_pkg::SAPR_IDLE) begin
      conv_cnt_next = 11'h000;
    end else begin
      conv_cnt_next = conv_cnt_reg + 11'h001;
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      conv_cnt_reg <= 11'h000;
    end else begin
      conv_cnt_reg <= conv_cnt_next;
    end
  end

  // Next-state logic. Every register but the tick counter defaults to its present value, so a state only names
  // what it changes.
  always_comb begin
    state_next = state_reg;
    sar_next   = sar_reg;
    trial_next = trial_reg;
    latch_next = latch_reg;
    // The tick counter restarts at every decision and rests at zero outside the step state.
    tick_next  = (state_reg == sapr_pkg::SAPR_STEP && !step_en) ? tick_reg + 8'h01 : 8'h00;
    case (state_reg)
      // Idle: only here is a start heard; in any other state it falls through unheard.
      sapr_pkg::SAPR_IDLE: begin
        if (start_req) begin
          state_next = sapr_pkg::SAPR_CLEAR;
        end
      end
      // Clear: one cycle that empties the register and puts the trial bit on the MSB.
      sapr_pkg::SAPR_CLEAR: begin
        sar_next   = 12'h000;
        trial_next = 12'h800;
        state_next = sapr_pkg::SAPR_STEP;
      end
      sapr_pkg::SAPR_STEP: begin
        // Comparator high keeps the trial bit; one decision per step.
        if (step_en) begin
          sar_next   = cmp_reg ? (sar_reg | trial_reg) : sar_reg;
          trial_next = trial_reg >> 1;
          if (last_bit) begin
            state_next = sapr_pkg::SAPR_LOAD;
          end
        end
        // The watchdog wins over the step clock; the bits still undecided stay zero.
        if (conv_late) begin
          state_next = sapr_pkg::SAPR_LOAD;
        end
      end
      // Load: one cycle, then idle; busy rises on the same edge as the latch takes the result.
      sapr_pkg::SAPR_LOAD: begin
        latch_next = sar_reg;
        state_next = sapr_pkg::SAPR_IDLE;
      end
      // An unused encoding returns to idle rather than hang with busy low.
      default: begin
        state_next = sapr_pkg::SAPR_IDLE;
      end
    endcase
  end

  // Sequencer registers; reset returns to idle with an empty output latch.
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state_reg <= sapr_pkg::SAPR_IDLE;
      sar_reg   <= 12'h000;
      trial_reg <= 12'h000;
      latch_reg <= 12'h000;
      tick_reg  <= 8'h00;
    end else begin
      state_reg <= state_next;
      sar_reg   <= sar_next;
      trial_reg <= trial_next;
      latch_reg <= latch_next;
      tick_reg  <= tick_next;
    end
  end

  // Busy and DAC code registered so the pins never glitch. Both are taken from the next-state
  // values, so busy falls on the very edge that leaves idle and rises on the edge that returns
  // there, with no cycle of lag against the sequencer.
  logic        busy_n_reg;
  logic        busy_n_next;
  logic [11:0] dac_reg;
  logic [11:0] dac_next;

  always_comb begin
    busy_n_next = (state_next == sapr_pkg::SAPR_IDLE);
    // Trial code: the bits kept so far plus the bit now on trial.
    dac_next    = sar_next | trial_next;
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      busy_n_reg <= 1'b1;
      dac_reg    <= 12'h000;
    end else begin
      busy_n_reg <= busy_n_next;
      dac_reg    <= dac_next;
    end
  end

  assign busy_n_o   = busy_n_reg;
  assign dac_code_o = dac_reg;

  // Byte select passes only while chip select is low. With select high the read strobe and
  // byte select are both masked here, so a deselected device neither drives its pins nor
  // changes their format.
  assign pins.drive_en  = read_act;
  assign pins.high_byte = hb_reg & ~sel_reg;
  assign pins.latch_val = latch_reg;

  // Pin driver registers data and enables, so the pins follow the strobes one cycle later.
  sapr_pin_drv u_drv (
    .clk_i       (clk_i),
    .rstn_i      (rstn_i),
    .pins        (pins),
    .data_o      (data_o),
    .data_oe_n_o (data_oe_n_o)
  );
endmodule

// >>> tb/sapr_analog_model.sv
// Comparator model standing in for the analog side of the converter.
`timescale 1ns/10ps
module sapr_analog_model (
  input  wire logic [11:0] dac_code_i,
  input  wire logic [11:0] level_i,
  output logic             comp_o
);
  // An ideal comparator, so that a finished conversion lands on the held level exactly.
  assign comp_o = (dac_code_i <= level_i);
endmodule

// >>> tb/sapr_ctrl_checker.sv
// Concurrent checks on the converter control ports.
`timescale 1ns/10ps
module sapr_ctrl_checker (
  input wire logic        clk_i,
  input wire logic        rstn_i,
  input wire logic        select_n_i,
  input wire logic        read_n_i,
  input wire logic        high_byte_select_i,
  input wire logic [11:0] dac_code_o,
  input wire logic        busy_n_o,
  input wire logic [11:0] data_o,
  input wire logic [11:0] data_oe_n_o
);
  logic [10:0] cnt_reg;
  logic [10:0] cnt_next;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  // Length of the busy period; eight-cycle runs below cover the three-flop input filters.
  assign cnt_next = busy_n_o ? 11'h000 : cnt_reg + 11'h001;
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) cnt_reg <= 11'h000;
    else cnt_reg <= cnt_next;
  end
  property p_start; $fell(read_n_i) && !select_n_i && !high_byte_select_i && busy_n_o |-> ##[1:8] !busy_n_o; endproperty
  a_start: assert property (p_start) else $error("No start.");
  property p_block; (select_n_i || high_byte_select_i)[*8] ##0 busy_n_o |=> busy_n_o; endproperty
  a_block: assert property (p_block) else $error("Bad start.");
  property p_off; (select_n_i || read_n_i)[*8] |-> data_oe_n_o == 12'hFFF; endproperty
  a_off: assert property (p_off) else $error("Pins driven.");
  property p_on; (!select_n_i && !read_n_i)[*8] |-> data_oe_n_o == 12'h000; endproperty
  a_on: assert property (p_on) else $error("Pins floating.");
  property p_len; $rose(busy_n_o) |-> cnt_reg == 11'h3C2; endproperty
  a_len: assert property (p_len) else $error("Busy length.");
  property p_clr; $fell(busy_n_o) |-> ##[0:3] dac_code_o == 12'h800; endproperty
  a_clr: assert property (p_clr) else $error("No clear.");
  property p_hb; (high_byte_select_i && !select_n_i && !read_n_i)[*8] |-> data_o[7:4] == 4'h0
    && data_o[3:0] == data_o[11:8]; endproperty
  a_hb: assert property (p_hb) else $error("Byte format.");
  property p_hold; (busy_n_o && select_n_i && !high_byte_select_i)[*8] |-> $stable(data_o); endproperty
  a_hold: assert property (p_hold) else $error("Latch moved.");
  c_conv: cover property ($rose(busy_n_o));
  c_byte: cover property ((high_byte_select_i && !select_n_i && !read_n_i)[*8]);
  c_desel: cover property ((select_n_i && !read_n_i)[*8]);
endmodule
bind sapr_ctrl sapr_ctrl_checker sapr_ctrl_checker_inst (.clk_i(clk_i), .rstn_i(rstn_i), .select_n_i(select_n_i),
  .read_n_i(read_n_i), .high_byte_select_i(high_byte_select_i), .dac_code_o(dac_code_o), .busy_n_o(busy_n_o),
  .data_o(data_o), .data_oe_n_o(data_oe_n_o));

// >>> tb/test_sapr_ctrl.sv
// Self-checking bench for the converter control block.
`timescale 1ns/10ps
module test_sapr_ctrl;
  logic        clk_i, rstn_i, select_n_i, read_n_i, high_byte_select_i, comp_i, busy_n_o;
  logic [11:0] dac_code_o, data_o, data_oe_n_o, level;
  int          mismatches, checked, cycles;
  sapr_ctrl sapr_ctrl_inst (.clk_i(clk_i), .rstn_i(rstn_i), .select_n_i(select_n_i), .read_n_i(read_n_i),
    .high_byte_select_i(high_byte_select_i), .comp_i(comp_i), .dac_code_o(dac_code_o), .busy_n_o(busy_n_o),
    .data_o(data_o), .data_oe_n_o(data_oe_n_o));
  sapr_analog_model sapr_analog_model_inst (.dac_code_i(dac_code_o), .level_i(level), .comp_o(comp_i));
  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end
  // A full run needs about 4800 cycles, so this ceiling only trips on a hang.
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      mismatches = mismatches + 1;
      end_of_test();
    end
  end
  task automatic check(input logic [11:0] seen, input logic [11:0] want);
    checked = checked + 1;
    if (seen !== want) begin
      mismatches = mismatches + 1;
      $display("[FAIL] %0t ns: saw %h, expected %h", $time, seen, want);
    end
  endtask
  // Pins change after an edge and hold; outputs are then looked at once they have settled.
  task automatic bus(input logic sel_n, input logic rd_n, input logic hb, input int hold);
    @(posedge clk_i);
    select_n_i <= sel_n;
    read_n_i <= rd_n;
    high_byte_select_i <= hb;
    repeat (hold) @(posedge clk_i);
    #1;
  endtask
  // Word read that starts a conversion, a retrigger attempt, then the sampling pause.
  task automatic t_start(input logic [11:0] lvl, input logic [11:0] prev);
    int n;
    level = lvl;
    bus(1'b0, 1'b0, 1'b0, 10);
    check({11'h000, busy_n_o}, 12'h000);
    check(data_oe_n_o, 12'h000);
    check(data_o, prev);
    bus(1'b1, 1'b1, 1'b0, 4);
    bus(1'b0, 1'b0, 1'b0, 6);
    bus(1'b1, 1'b1, 1'b0, 4);
    for (n = 0; n < 1200 && busy_n_o !== 1'b1; n++) begin
      @(posedge clk_i);
      #1;
    end
    check({11'h000, busy_n_o}, 12'h001);
    bus(1'b1, 1'b1, 1'b0, 210);
  endtask
  // Two-byte read: no start, upper nibble on both ends, middle pins low.
  task automatic t_byte(input logic [11:0] lvl);
    bus(1'b0, 1'b0, 1'b1, 10);
    check({11'h000, busy_n_o}, 12'h001);
    check(data_o, {lvl[11:8], 4'h0, lvl[11:8]});
    bus(1'b1, 1'b1, 1'b1, 10);
    check(data_oe_n_o, 12'hFFF);
  endtask
  // Read strobe with the device deselected must be ignored entirely.
  task automatic t_desel();
    bus(1'b1, 1'b0, 1'b0, 10);
    check({11'h000, busy_n_o}, 12'h001);
    check(data_oe_n_o, 12'hFFF);
    bus(1'b1, 1'b1, 1'b0, 10);
  endtask
  task automatic end_of_test();
    $display("Mismatches %0d, comparisons %0d", mismatches, checked);
    if (mismatches == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    {select_n_i, read_n_i, high_byte_select_i} = 3'b110;
    rstn_i = 1'b0;
    level = 12'h000;
    mismatches = 0;
    checked = 0;
    cycles = 0;
    repeat (3) @(posedge clk_i);
    rstn_i <= 1'b1;
    t_start(12'hA5C, 12'h000);
    t_start(12'h3F1, 12'hA5C);
    t_byte(12'h3F1);
    t_desel();
    t_start(12'hFFF, 12'h3F1);
    t_start(12'h000, 12'hFFF);
    t_byte(12'h000);
    end_of_test();
  end
endmodule
